/* File: rtl/scc_pkg.sv */
/*
 * scc_pkg: constants and types of the system control coprocessor
 * register block (regions, cache operations, lockdown, test bits).
 * Assumes a single core clock and a core that issues one coprocessor
 * transfer at a time and holds it while the wait output is low.
 */
package scc_pkg;

	// coprocessor register numbers
	localparam logic [3:0] CRN_REGION  = 4'h6;
	localparam logic [3:0] CRN_CACHEOP = 4'h7;
	localparam logic [3:0] CRN_LOCK    = 4'h9;
	localparam logic [3:0] CRN_TEST    = 4'hf;

	// cache operation selectors
	localparam logic [3:0] CRM_WFI     = 4'h0;
	localparam logic [3:0] CRM_INV_I   = 4'h5;
	localparam logic [3:0] CRM_INV_D   = 4'h6;
	localparam logic [3:0] CRM_WFI_ALT = 4'h8;
	localparam logic [3:0] CRM_CLEAN_D = 4'ha;
	localparam logic [3:0] CRM_PREF_I  = 4'hd;
	localparam logic [3:0] CRM_CLINV_D = 4'he;
	localparam logic [3:0] CRM_TEST    = 4'h0;
	localparam logic [2:0] OP2_ALL     = 3'h0;
	localparam logic [2:0] OP2_PREF    = 3'h1;
	localparam logic [2:0] OP2_LINE    = 3'h2;
	localparam logic [2:0] OP2_WFI     = 3'h4;
	localparam logic [2:0] OP2_DRAIN   = 3'h4;
	localparam logic [2:0] OP2_DATA    = 3'h0;
	localparam logic [2:0] OP2_INSTR   = 3'h1;

	// field positions
	localparam int BASE_LSB  = 12;
	localparam int SIZE_LSB  = 1;
	localparam int EN_BIT    = 0;
	localparam int INDEX_LSB = 26;
	localparam int SEG_LSB   = 4;
	localparam int PADDR_LSB = 6;
	localparam int LOAD_BIT  = 31;
	localparam int IRR_BIT   = 3;
	localparam int DRR_BIT   = 2;

	localparam int           NUM_REGIONS = 8;
	localparam logic [4:0]   SIZE_MIN    = 5'h0b;
	localparam logic [31:0]  RESET_WORD  = 32'h0000_0000;

	// synchroniser bit positions
	localparam int SY_FIQ = 0;
	localparam int SY_IRQ = 1;
	localparam int SY_DBG = 2;
	localparam int SY_EN  = 3;
	localparam logic [3:0] SYNC_RESET = 4'h3;

	typedef enum logic [1:0] {MODE_RUN, MODE_WFI, MODE_DRAIN} scc_mode_t;

	typedef enum logic [2:0] {
		OP_INV_I_ALL, OP_INV_I_LINE, OP_INV_D_ALL, OP_INV_D_LINE,
		OP_CLEAN_D_LINE, OP_CLINV_D_LINE, OP_PREFETCH_I
	} scc_op_kind_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  crn;
		logic [3:0]  secondary_register_field;
		logic [2:0]  op2;
		logic [31:0] wdata;
	} scc_req_t;

	typedef struct packed {
		logic         valid;
		scc_op_kind_t kind;
		logic [5:0]   index;
		logic [1:0]   seg;
		logic [25:0]  addr;
	} scc_op_t;

	typedef struct packed {
		logic [19:0] base;
		logic [4:0]  size;
		logic        en;
	} scc_region_t;

	typedef struct packed {
		logic [19:0] base;
		logic [5:0]  size_log2;
		logic        size_ok;
		logic        en;
	} scc_region_info_t;

	typedef struct packed {
		logic       load;
		logic [5:0] index;
	} scc_lock_t;

endpackage

/* File: rtl/scc_regs.sv */
/*
 * scc_regs: system control coprocessor register logic for protection
 * regions, cache operations, lockdown and replacement test bits.
 * Assumes the core holds a transfer while coproc_wait_n_o is low, that
 * wb_empty_i and dbg_unit_req_i come from logic on clk_sys_i, and that
 * the interrupt, debug request and debug enable inputs are pins.
 */
// What this block does
// - region word: base 31:12, size 5:1, enable bit 0; reset clears enable
// - size code 0b01011 is 4KB, doubling per step to 4GB; lower reserved
// - cache operations register is write-only; reads start nothing
// - c5/c6 invalidate whole cache with opcode2 0, one entry with 2
// - c10 op2 2 cleans a data entry; c14 op2 2 cleans then invalidates
// - c13 op2 1 prefetches an instruction line: address 31:6, segment 5:4
// - indexed operations take index from bit 26 up, segment from 5:4
// - c7 c0 op2 4 or register 15 c8 op2 2 freezes clocks until wake
// - either interrupt request wakes the block, ignoring the mask bits
// - debug requests wake the block only while debug enable is high
// - wake cause is reported so the core interrupts or enters debug
// - c10 op2 4 stalls the core until the write buffer is empty
// - lockdown: op2 0 data, 1 instruction; load bit 31, index 5:0
// - lockdown covers the index in all four segments together
// - test bit 3 and bit 2 pick round-robin for instruction, data cache
// - eight instruction and eight data regions are provided
// - region picked by secondary field number and opcode2 data or instr
`timescale 1ns/100ps
module scc_regs
	import scc_pkg::*;
(
	// clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rst_i,
	// coprocessor transfer from the core
	input  wire scc_req_t         cp_req_i,
	output logic                  coproc_wait_n_o,
	output logic [31:0]           cp_rdata_o,
	// pins
	input  wire logic             fast_int_req_n_i,
	input  wire logic             normal_int_req_n_i,
	input  wire logic             ext_debug_request_i,
	input  wire logic             debug_enable_pin_i,
	// on-chip status
	input  wire logic             dbg_unit_req_i,
	input  wire logic             wb_empty_i,
	// towards caches, protection unit and clock control
	output scc_op_t               cache_op_o,
	output scc_region_info_t      region_o [2*NUM_REGIONS],
	output scc_lock_t             dlock_o,
	output scc_lock_t             ilock_o,
	output logic                  instruction_cache_round_robin_o,
	output logic                  data_cache_round_robin_o,
	output logic                  clk_freeze_o,
	output logic                  wake_int_o,
	output logic                  wake_debug_o
);

	typedef struct packed {
		scc_mode_t                      mode;
		scc_region_t [2*NUM_REGIONS-1:0] region;
		scc_lock_t                      dlock;
		scc_lock_t                      ilock;
		logic                           irr;
		logic                           drr;
		scc_op_t                        op;
		logic [31:0]                    rdata;
		logic                           wake_int;
		logic                           wake_dbg;
		logic [3:0]                     sync1;
		logic [3:0]                     sync2;
	} scc_state_t;

	scc_state_t st;
	scc_state_t next_st;
	logic       wake_int;
	logic       wake_dbg;
	logic       take;
	logic [3:0] ridx;

	// masks in the status register play no part in waking
	assign wake_int = !st.sync2[SY_FIQ] || !st.sync2[SY_IRQ];
	assign wake_dbg = st.sync2[SY_EN] &&
		(st.sync2[SY_DBG] || dbg_unit_req_i);
	assign take = cp_req_i.valid && st.mode == MODE_RUN;
	// data regions at 0..7, instruction regions at 8..15
	assign ridx = {cp_req_i.op2[0], cp_req_i.secondary_register_field[2:0]};

	always_comb begin
		next_st = st;
		next_st.op.valid = 1'b0;
		next_st.wake_int = 1'b0;
		next_st.wake_dbg = 1'b0;
		next_st.sync1 = {debug_enable_pin_i, ext_debug_request_i,
			normal_int_req_n_i, fast_int_req_n_i};
		next_st.sync2 = st.sync1;
		unique case (st.mode)
			MODE_RUN: begin
				if (take && cp_req_i.write) begin
					unique case (cp_req_i.crn)
						CRN_REGION: begin
							if (cp_req_i.secondary_register_field[3] == 1'b0 &&
								cp_req_i.op2[2:1] == 2'b00) begin
								next_st.region[ridx].base =
									cp_req_i.wdata[31:BASE_LSB];
								next_st.region[ridx].size =
									cp_req_i.wdata[5:SIZE_LSB];
								next_st.region[ridx].en =
									cp_req_i.wdata[EN_BIT];
							end
						end
						CRN_CACHEOP: begin
							next_st.op.index = cp_req_i.wdata[31:INDEX_LSB];
							next_st.op.seg = cp_req_i.wdata[5:SEG_LSB];
							next_st.op.addr = cp_req_i.wdata[31:PADDR_LSB];
							if (cp_req_i.secondary_register_field == CRM_INV_I &&
								cp_req_i.op2 == OP2_ALL) begin
								next_st.op.valid = 1'b1;
								next_st.op.kind = OP_INV_I_ALL;
							end
							if (cp_req_i.secondary_register_field == CRM_INV_I &&
								cp_req_i.op2 == OP2_LINE) begin
								next_st.op.valid = 1'b1;
								next_st.op.kind = OP_INV_I_LINE;
							end
							if (cp_req_i.secondary_register_field == CRM_INV_D &&
								cp_req_i.op2 == OP2_ALL) begin
								next_st.op.valid = 1'b1;
								next_st.op.kind = OP_INV_D_ALL;
							end
							if (cp_req_i.secondary_register_field == CRM_INV_D &&
								cp_req_i.op2 == OP2_LINE) begin
								next_st.op.valid = 1'b1;
								next_st.op.kind = OP_INV_D_LINE;
							end
							if (cp_req_i.secondary_register_field == CRM_CLEAN_D &&
								cp_req_i.op2 == OP2_LINE) begin
								next_st.op.valid = 1'b1;
								next_st.op.kind = OP_CLEAN_D_LINE;
							end
							if (cp_req_i.secondary_register_field == CRM_CLINV_D &&
								cp_req_i.op2 == OP2_LINE) begin
								next_st.op.valid = 1'b1;
								next_st.op.kind = OP_CLINV_D_LINE;
							end
							if (cp_req_i.secondary_register_field == CRM_PREF_I &&
								cp_req_i.op2 == OP2_PREF) begin
								next_st.op.valid = 1'b1;
								next_st.op.kind = OP_PREFETCH_I;
							end
							if (cp_req_i.secondary_register_field == CRM_WFI &&
								cp_req_i.op2 == OP2_WFI)
								next_st.mode = MODE_WFI;
							if (cp_req_i.secondary_register_field == CRM_CLEAN_D &&
								cp_req_i.op2 == OP2_DRAIN)
								next_st.mode = MODE_DRAIN;
						end
						CRN_LOCK: begin
							// no segment field: one index locks all four segments
							if (cp_req_i.op2 == OP2_DATA) begin
								next_st.dlock.load = cp_req_i.wdata[LOAD_BIT];
								next_st.dlock.index = cp_req_i.wdata[5:0];
							end
							if (cp_req_i.op2 == OP2_INSTR) begin
								next_st.ilock.load = cp_req_i.wdata[LOAD_BIT];
								next_st.ilock.index = cp_req_i.wdata[5:0];
							end
						end
						CRN_TEST: begin
							if (cp_req_i.secondary_register_field == CRM_TEST &&
								cp_req_i.op2 == OP2_ALL) begin
								next_st.irr = cp_req_i.wdata[IRR_BIT];
								next_st.drr = cp_req_i.wdata[DRR_BIT];
							end
							if (cp_req_i.secondary_register_field == CRM_WFI_ALT &&
								cp_req_i.op2 == OP2_LINE)
								next_st.mode = MODE_WFI;
						end
						// reserved numbers are ignored
						default: ;
					endcase
				end
				if (take && !cp_req_i.write) begin
					next_st.rdata = RESET_WORD;
					if (cp_req_i.crn == CRN_REGION)
						next_st.rdata = {st.region[ridx].base, 6'h00,
							st.region[ridx].size, st.region[ridx].en};
					if (cp_req_i.crn == CRN_LOCK && cp_req_i.op2 == OP2_DATA)
						next_st.rdata = {st.dlock.load, 25'h000_0000,
							st.dlock.index};
					if (cp_req_i.crn == CRN_LOCK && cp_req_i.op2 == OP2_INSTR)
						next_st.rdata = {st.ilock.load, 25'h000_0000,
							st.ilock.index};
					if (cp_req_i.crn == CRN_TEST)
						next_st.rdata = {28'h000_0000, st.irr, st.drr, 2'h0};
				end
			end
			MODE_WFI: begin
				// interrupt wins when both causes arrive together
				if (wake_int || wake_dbg) begin
					next_st.mode = MODE_RUN;
					next_st.wake_int = wake_int;
					next_st.wake_dbg = !wake_int;
				end
			end
			MODE_DRAIN: begin
				if (wb_empty_i)
					next_st.mode = MODE_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st <= '0;
			st.sync1 <= SYNC_RESET;
			st.sync2 <= SYNC_RESET;
		end else begin
			st <= next_st;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2*NUM_REGIONS; g++) begin : g_region
			assign region_o[g].base = st.region[g].base;
			assign region_o[g].en = st.region[g].en;
			assign region_o[g].size_ok = st.region[g].size >= SIZE_MIN;
			// log2 of bytes is the code plus one: 0b01011 gives 2^12
			assign region_o[g].size_log2 =
				6'({1'b0, st.region[g].size} + 6'h01);
		end
	endgenerate

	// the core is frozen in standby, so no transfer may be taken there
	assign coproc_wait_n_o = st.mode == MODE_RUN;
	assign clk_freeze_o = st.mode == MODE_WFI;
	assign cp_rdata_o = st.rdata;
	assign cache_op_o = st.op;
	assign dlock_o = st.dlock;
	assign ilock_o = st.ilock;
	assign instruction_cache_round_robin_o = st.irr;
	assign data_cache_round_robin_o = st.drr;
	assign wake_int_o = st.wake_int;
	assign wake_debug_o = st.wake_dbg;

	chk_enable_reset: assert property (@(posedge clk_sys_i)
		$past(rst_i) |-> region_o[0].en == 1'b0 && region_o[15].en == 1'b0)
		else $error("region enable not cleared by reset");

	chk_size_decode: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		region_o[3].size_ok |-> region_o[3].size_log2 == 6'h0c +
			6'(st.region[3].size - SIZE_MIN))
		else $error("region size decode wrong");

	chk_read_noop: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		take && !cp_req_i.write && cp_req_i.crn == CRN_CACHEOP
		|=> !cache_op_o.valid && coproc_wait_n_o)
		else $error("read of cache operations started something");

	chk_flush_instruction_cache: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		take && cp_req_i.write && cp_req_i.crn == CRN_CACHEOP &&
		cp_req_i.secondary_register_field == CRM_INV_I && cp_req_i.op2 == OP2_ALL
		|=> cache_op_o.valid && cache_op_o.kind == OP_INV_I_ALL ##1
		(!cache_op_o.valid || $past(take && cp_req_i.write)))
		else $error("instruction cache flush not issued once");

	chk_clean_index: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		take && cp_req_i.write && cp_req_i.crn == CRN_CACHEOP &&
		cp_req_i.secondary_register_field == CRM_CLINV_D && cp_req_i.op2 == OP2_LINE
		|=> cache_op_o.kind == OP_CLINV_D_LINE &&
		cache_op_o.index == $past(cp_req_i.wdata[31:26]) &&
		cache_op_o.seg == $past(cp_req_i.wdata[5:4]))
		else $error("clean and invalidate index or segment wrong");

	chk_prefetch_addr: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		take && cp_req_i.write && cp_req_i.crn == CRN_CACHEOP &&
		cp_req_i.secondary_register_field == CRM_PREF_I && cp_req_i.op2 == OP2_PREF
		|=> cache_op_o.kind == OP_PREFETCH_I &&
		cache_op_o.addr == $past(cp_req_i.wdata[31:6]))
		else $error("prefetch address wrong");

	chk_wfi_entry: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		take && cp_req_i.write && cp_req_i.crn == CRN_TEST &&
		cp_req_i.secondary_register_field == CRM_WFI_ALT && cp_req_i.op2 == OP2_LINE
		|=> clk_freeze_o && !coproc_wait_n_o)
		else $error("standby not entered");

	chk_irq_wake: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		clk_freeze_o && !st.sync2[SY_IRQ] |=> !clk_freeze_o && wake_int_o)
		else $error("interrupt request did not wake");

	chk_debug_gate: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		clk_freeze_o && !st.sync2[SY_EN] && st.sync2[SY_FIQ] &&
		st.sync2[SY_IRQ] |=> clk_freeze_o && !wake_debug_o)
		else $error("debug woke while debug disabled");

	chk_drain_stall: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		st.mode == MODE_DRAIN && !wb_empty_i |=> !coproc_wait_n_o)
		else $error("drain released before write buffer empty");

	chk_test_readback: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		take && !cp_req_i.write && cp_req_i.crn == CRN_TEST
		|=> cp_rdata_o == {28'h000_0000, instruction_cache_round_robin_o,
		data_cache_round_robin_o, 2'h0})
		else $error("test register readback wrong");

	cov_wfi_irq: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		clk_freeze_o ##1 wake_int_o);
	cov_wfi_dbg: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		clk_freeze_o ##1 wake_debug_o);
	cov_drain: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		st.mode == MODE_DRAIN && !wb_empty_i ##1 coproc_wait_n_o);

endmodule // scc_regs

/* File: verif/scc_core_model.sv */
/*
 * scc_core_model: behavioural core that issues one coprocessor transfer
 * at a time. Assumes the block takes a transfer at a rising edge while
 * its wait output is high, and that wait only changes on clock edges.
 */
`timescale 1ns/100ps
module scc_core_model
	import scc_pkg::*;
(
	// clock and stall
	input  wire logic clk_sys_i,
	input  wire logic coproc_wait_n_i,
	// transfer towards the block
	output scc_req_t  cp_req_o
);
	logic ok;

	initial cp_req_o = '0;

	// held whole until taken; callers use implemented numbers only
	task automatic xfer(input logic wr, input logic [3:0] crn,
		input logic [3:0] secondary_register_field, input logic [2:0] op2,
		input logic [31:0] wd);
		@(posedge clk_sys_i);
		#1;
		cp_req_o = '{1'b1, wr, crn, secondary_register_field, op2, wd};
		// wait is read 1 ns after each edge, where it already shows
		// what the next edge will sample; reading it at the edge
		// itself would see the old value and offer the transfer twice
		do begin
			ok = coproc_wait_n_i;
			@(posedge clk_sys_i);
			#1;
		end while (ok !== 1'b1);
		// released lines show garbage, never the last value
		cp_req_o = '{1'b0, ~wr, ~crn, ~secondary_register_field, ~op2, ~wd};
	endtask
endmodule // scc_core_model

/* File: verif/scc_regs_tb.sv */
/*
 * scc_regs_tb: self-checking bench for the coprocessor register block.
 * Assumes the core model drives transfers and the bench drives pins,
 * write buffer status and reset, all 1 ns after the rising edge.
 */
`timescale 1ns/100ps
module scc_regs_tb;
	import scc_pkg::*;

	logic             clk_sys_i = 1'b0;
	logic             rst_i = 1'b1;
	scc_req_t         cp_req;
	logic             wait_n, freeze, w_int, w_dbg, irr, drr;
	logic [31:0]      rdata;
	logic             fiq_n = 1'b1, irq_n = 1'b1, edbg = 1'b0;
	logic             den = 1'b0, dunit = 1'b0, wb_empty = 1'b1;
	scc_op_t          op, last_op;
	scc_region_info_t region [2*NUM_REGIONS];
	scc_lock_t        dlock, ilock;
	int               miscompares = 0, n_checks = 0, cycles = 0;
	int               n_ops = 0, n_wint = 0, n_wdbg = 0;

	scc_core_model core (.clk_sys_i(clk_sys_i), .coproc_wait_n_i(wait_n),
		.cp_req_o(cp_req));

	scc_regs uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cp_req_i(cp_req),
		.coproc_wait_n_o(wait_n), .cp_rdata_o(rdata),
		.fast_int_req_n_i(fiq_n), .normal_int_req_n_i(irq_n),
		.ext_debug_request_i(edbg), .debug_enable_pin_i(den),
		.dbg_unit_req_i(dunit), .wb_empty_i(wb_empty), .cache_op_o(op),
		.region_o(region), .dlock_o(dlock), .ilock_o(ilock),
		.instruction_cache_round_robin_o(irr), .data_cache_round_robin_o(drr),
		.clk_freeze_o(freeze), .wake_int_o(w_int), .wake_debug_o(w_dbg));

	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// pulses are counted here so their exact latency does not matter
	always @(posedge clk_sys_i) begin
		cycles++;
		n_wint += (w_int === 1'b1);
		n_wdbg += (w_dbg === 1'b1);
		if (op.valid === 1'b1) begin
			n_ops++;
			last_op = op;
		end
		if (cycles == 3000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic rd(input logic [3:0] crn, input logic [3:0] secondary_register_field,
		input logic [2:0] op2, input logic [31:0] exp);
		core.xfer(1'b0, crn, secondary_register_field, op2, 32'h0000_0000);
		cyc(1);
		check(rdata === exp, "read back");
	endtask

	task automatic do_reset();
		rst_i = 1'b1;
		cyc(12);
		rst_i = 1'b0;
	endtask

	task automatic t_reset();
		for (int i = 0; i < 16; i++) begin
			check(region[i].en === 1'b0, "enable after reset");
		end
		check(wait_n === 1'b1 && freeze === 1'b0 &&
			{dlock, ilock, irr, drr} === 16'h0000, "reset state");
	endtask

	task automatic t_regions();
		logic [31:0] w [16];
		for (int i = 0; i < 16; i++) begin
			// base aligned to the region size 2**(code+1)
			w[i] = ((32'(i) + 1) << (i + 11)) & 32'hffff_f000;
			w[i] = w[i] | {26'h0, 5'(i + 10), i[0]};
			core.xfer(1'b1, CRN_REGION, 4'(i % 8), 3'(i / 8), w[i]);
		end
		cyc(1);
		for (int i = 0; i < 16; i++) begin
			check(region[i].base === w[i][31:12] &&
				region[i].en === w[i][0], "region fields");
			check(region[i].size_log2 === 6'(i + 11) &&
				region[i].size_ok === (i >= 1), "size decode");
			rd(CRN_REGION, 4'(i % 8), 3'(i / 8), w[i]);
		end
	endtask

	task automatic t_ops();
		logic [3:0] secondary_register_field [7] = '{CRM_INV_I, CRM_INV_I, CRM_INV_D, CRM_INV_D,
			CRM_CLEAN_D, CRM_CLINV_D, CRM_PREF_I};
		logic [2:0] o2 [7] = '{OP2_ALL, OP2_LINE, OP2_ALL, OP2_LINE,
			OP2_LINE, OP2_LINE, OP2_PREF};
		scc_op_kind_t k [7] = '{OP_INV_I_ALL, OP_INV_I_LINE, OP_INV_D_ALL,
			OP_INV_D_LINE, OP_CLEAN_D_LINE, OP_CLINV_D_LINE, OP_PREFETCH_I};
		int n;
		logic [31:0] d;
		for (int i = 0; i < 7; i++) begin
			n = n_ops;
			d = {6'(i * 9 + 1), (i == 6) ? 20'h5_a5a5 : 20'h0_0000,
				2'(i), 4'h0};
			core.xfer(1'b1, CRN_CACHEOP, secondary_register_field[i], o2[i], d);
			cyc(3);
			check(n_ops === n + 1 && last_op.kind === k[i], "op kind");
			check(last_op.index === d[31:26] &&
				last_op.seg === d[5:4], "index seg");
			check(last_op.addr === d[31:6], "prefetch address");
		end
		n = n_ops;
		core.xfer(1'b0, CRN_CACHEOP, CRM_INV_I, OP2_ALL, 32'h0000_0000);
		cyc(3);
		check(n_ops === n, "read started an operation");
	endtask

	task automatic t_lock();
		core.xfer(1'b1, CRN_LOCK, 4'h0, OP2_DATA, 32'h8000_002a);
		core.xfer(1'b1, CRN_LOCK, 4'h0, OP2_INSTR, 32'h0000_0015);
		core.xfer(1'b1, CRN_TEST, CRM_TEST, 3'h0, 32'h0000_0008);
		cyc(1);
		check({dlock, ilock} === 14'h3515, "lockdown");
		check(irr === 1'b1 && drr === 1'b0, "instruction_cache round robin");
		rd(CRN_LOCK, 4'h0, OP2_DATA, 32'h8000_002a);
		rd(CRN_LOCK, 4'h0, OP2_INSTR, 32'h0000_0015);
		rd(CRN_TEST, CRM_TEST, 3'h0, 32'h0000_0008);
		core.xfer(1'b1, CRN_TEST, CRM_TEST, 3'h0, 32'h0000_0004);
		cyc(1);
		check(irr === 1'b0 && drr === 1'b1, "data_cache round robin");
	endtask

	task automatic t_drain();
		wb_empty = 1'b0;
		core.xfer(1'b1, CRN_CACHEOP, CRM_CLEAN_D, OP2_DRAIN, 32'h0000_0000);
		// a lockdown write offered during the stall must wait for release
		fork
			core.xfer(1'b1, CRN_LOCK, 4'h0, OP2_DATA, 32'h0000_0011);
			begin
				cyc(5);
				check(wait_n === 1'b0, "drain released early");
				check(dlock === 7'h6a, "taken in stall");
				wb_empty = 1'b1;
			end
		join
		cyc(3);
		check(wait_n === 1'b1, "drain never released");
		check(dlock === 7'h11, "held write lost");
	endtask

	// c: 0 fast, 1 normal, 2 pin debug, 3 unit debug, 4 debug disabled
	task automatic t_wfi(input int c);
		int n;
		int m;
		n = n_wint;
		m = n_wdbg;
		den = (c != 4);
		cyc(4);
		if (c % 2 == 1) begin
			core.xfer(1'b1, CRN_CACHEOP, CRM_WFI, OP2_WFI, 32'h0000_0000);
		end else begin
			core.xfer(1'b1, CRN_TEST, CRM_WFI_ALT, 3'h2, 32'h0000_0000);
		end
		cyc(4);
		check(freeze === 1'b1 && wait_n === 1'b0, "no standby");
		case (c)
			0: fiq_n = 1'b0;
			1: irq_n = 1'b0;
			2: edbg = 1'b1;
			default: dunit = 1'b1;
		endcase
		cyc(6);
		check(freeze === (c == 4), "wake");
		check(n_wint === n + (c < 2) &&
			n_wdbg === m + (c == 2 || c == 3), "wake cause");
		{fiq_n, irq_n, edbg, dunit} = 4'b1100;
		if (c == 4) begin
			irq_n = 1'b0;
			cyc(6);
			irq_n = 1'b1;
		end
		cyc(4);
		check(freeze === 1'b0 && wait_n === 1'b1, "still frozen");
	endtask

	initial begin
		do_reset();
		t_reset();
		t_regions();
		t_ops();
		t_lock();
		t_drain();
		for (int c = 0; c < 5; c++) begin
			t_wfi(c);
		end
		do_reset();
		t_reset();
		conclude();
	end
endmodule // scc_regs_tb
